// file: common/comp_pkg.sv
package comp_pkg;
   // Pixel and factor widths
   localparam int PW = 10;
   localparam int NKEY = 4;
   localparam logic [8:0] F_FULL = 9'h100;
   localparam logic [PW-1:0] BLACK = 10'h040;
   localparam logic [PW-1:0] PIX_MAX = 10'h3FF;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD = 8'h04;
   localparam logic [7:0] A_RATE = 8'h08;
   localparam logic [7:0] A_KRATE = 8'h0C;
   localparam logic [7:0] A_BUS = 8'h10;
   localparam logic [7:0] A_PRIO = 8'h14;
   localparam logic [7:0] A_KCFG = 8'h18;
   localparam logic [7:0] A_CLIP = 8'h1C;
   localparam logic [7:0] A_GEN = 8'h20;
   localparam logic [7:0] A_MATTE = 8'h24;
   localparam logic [7:0] A_STAT = 8'h28;
   // Control field positions
   localparam int C_TYPE = 0;
   localparam int C_BG = 2;
   localparam int C_KEY = 3;
   localparam int C_PRIO = 7;
   localparam int C_PBLK = 8;
   localparam int C_WBG = 9;
   localparam int C_WKEY = 10;
   localparam int C_LEVER = 11;
   localparam int C_W0G = 12;
   localparam int C_W1G = 13;
   // Command field positions
   localparam int M_AUTO = 0;
   localparam int M_CUT = 1;
   localparam int M_KMIX = 4;
   // Per key configuration field positions
   localparam int K_LUMA = 0;
   localparam int K_SELF = 1;
   localparam int K_MATTE = 2;
   localparam int K_UNSH = 3;
   localparam int K_SHAPED = 4;
   localparam int K_MASK = 5;
   localparam int K_MBOX = 6;
   // Reset values
   localparam logic [31:0] R_CTRL = 32'h00000201;
   localparam logic [31:0] R_RATE = 32'h00000008;
   localparam logic [31:0] R_KRATE = 32'h08080808;
   localparam logic [31:0] R_BUS = 32'h00000004;
   localparam logic [31:0] R_PRIO = 32'h0000E4E4;
   localparam logic [31:0] R_CLIP = 32'h01000100;
   localparam logic [31:0] R_GEN = 32'h00004000;
   localparam logic [31:0] R_MATTE = 32'h00000200;
   // Fixed clip and gain for sources that arrive shaped
   localparam logic [PW-1:0] STD_CLIP = 10'h040;
   localparam logic [PW-1:0] STD_GAIN = 10'h36C;
   // Transition types and sequencer states
   typedef enum logic [1:0] {TT_CUT, TT_MIX, TT_WIPE} trans_type_t;
   typedef enum logic [1:0] {ST_IDLE, ST_AUTO, ST_LEVER} trans_state_t;

   // Weighted blend of a toward b, f of 256
   function automatic logic [PW-1:0] blend(input logic [PW-1:0] a, input logic [PW-1:0] b,
                                           input logic [8:0] f);
      logic [18:0] s;
      s = 19'(a) * 19'(F_FULL - f) + 19'(b) * 19'(f);
      return s[17:8];
   endfunction : blend
endpackage : comp_pkg

// file: rtl/key_layer.sv
`timescale 1ns/1ps
module key_layer (
   input wire logic [comp_pkg::PW-1:0] bg,
   input wire logic [comp_pkg::PW-1:0] cut,
   input wire logic [comp_pkg::PW-1:0] fill,
   input wire logic [comp_pkg::PW-1:0] matte,
   input wire logic [7:0] cfg,
   input wire logic [comp_pkg::PW-1:0] clip,
   input wire logic [comp_pkg::PW-1:0] gain,
   input wire logic [8:0] opacity,
   input wire logic mask_in,
   output logic [comp_pkg::PW-1:0] comp
);
   import comp_pkg::*;

   logic [PW-1:0] cut_src; // Cut signal actually used
   logic [PW-1:0] fill_src; // Video or matte fill
   logic [PW-1:0] use_clip;
   logic [PW-1:0] use_gain;
   logic [PW-1:0] diff; // Cut level above clip
   logic [17:0] ratio;
   logic [8:0] k_cg; // Clip and gain control
   logic [8:0] k_raw; // Key control signal
   logic [8:0] k_op; // Control after opacity
   logic [17:0] kprod;
   logic [17:0] unsh;
   logic [PW-1:0] fill_un;
   logic [PW-1:0] fill_sh;
   logic [PW:0] sum;

   // Self key reuses the fill as its own cut
   assign cut_src = cfg[K_SELF] ? fill : cut; // [RULE13]
   assign fill_src = cfg[K_MATTE] ? matte : fill; // [RULE13]
   // Shaped sources ignore operator clip and gain
   assign use_clip = cfg[K_SHAPED] ? STD_CLIP : clip; // [RULE18]
   assign use_gain = cfg[K_SHAPED] ? STD_GAIN : gain; // [RULE18]
   // Dark parts below clip leave the background alone
   assign diff = (cut_src > use_clip) ? cut_src - use_clip : '0; // [RULE14]
   assign ratio = (use_gain == '0) ? 18'h00000 : (18'(diff) << 8) / 18'(use_gain);
   assign k_cg = (use_gain == '0) ? ((diff != '0) ? F_FULL : 9'h000) :
                 ((ratio >= 18'(F_FULL)) ? F_FULL : ratio[8:0]); // [RULE14]
   // Luminance and shaped keys use clip/gain, linear keys the raw cut
   assign k_raw = !(cfg[K_MASK] && !mask_in) ?
                  ((cfg[K_LUMA] || cfg[K_SHAPED]) ? k_cg : 9'(cut_src >> 2)) : 9'h000;
   assign kprod = 18'(k_raw) * 18'(opacity);
   assign k_op = kprod[16:8];
   // Divide shaped video by its own key; small keys blow up edges
   assign unsh = (k_raw == '0) ? 18'(fill_src) : (18'(fill_src) << 8) / 18'(k_raw); // [RULE17]
   assign fill_un = (unsh > 18'(PIX_MAX)) ? PIX_MAX : unsh[PW-1:0]; // [RULE17]
   // Unshaped fill is multiplied by the same control that cut the hole
   assign fill_sh = (cfg[K_SHAPED] && !cfg[K_UNSH]) ? fill_src :
                    blend('0, cfg[K_UNSH] ? fill_un : fill_src, k_raw); // [RULE15] [RULE16]
   // Holed background plus shaped fill, held at white
   assign sum = (PW+1)'(blend(bg, '0, k_op)) + (PW+1)'(blend('0, fill_sh, opacity));
   assign comp = sum[PW] ? PIX_MAX : sum[PW-1:0];
endmodule : key_layer

// file: rtl/me_compositor.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// How it works
// RULE1: Wipe reveals new picture; backgrounds, keys or both
// RULE2: Two wipe systems, each picks a complex generator
// RULE3: Six pattern generators, also used for masking
// RULE4: Preset black: two commands, whole picture black
// RULE5: Cut instant; mix and wipe by rate or lever
// RULE6: Main rate plus per-key rate and trigger
// RULE7: Background buses swap at completion, output unchanged
// RULE8: Look-ahead preview shows the next stack
// RULE9: Next stack = current plus selected elements
// RULE10: Blend full current composite into full next composite
// RULE11: Highest priority key on top, background beneath
// RULE12: Priority change blends old order to new order
// RULE13: Key from background, cut, fill or matte; self key (code: cut from cut or fill only, fill from fill or matte)
// RULE14: Luminance key clips dark cut away
// RULE15: Unshaped fill multiplied by key control
// RULE16: Fill shaped with the same cut signal
// RULE17: Unshape by dividing by own key
// RULE18: Shaped sources use fixed clip and gain
// RULE19: Cut switches at a field boundary
// RULE20: Mix fades incoming up, outgoing down
// RULE21: Position updated once per field
// RULE22: Bus swap happens at a field boundary
module me_compositor #(
   parameter int NSRC = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pix_valid,
   input wire logic line_start,
   input wire logic field_start,
   input wire logic [NSRC-1:0][comp_pkg::PW-1:0] src_video,
   input wire logic [comp_pkg::NKEY-1:0][comp_pkg::PW-1:0] key_cut,
   input wire logic [comp_pkg::NKEY-1:0][comp_pkg::PW-1:0] key_fill,
   input wire logic [8:0] lever_pos,
   output logic [comp_pkg::PW-1:0] pgm_video,
   output logic [comp_pkg::PW-1:0] pvw_video,
   output logic out_valid
);
   import comp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0] ctrl_q, rate_q, krate_q, bus_q, prio_q, kcfg_q, clip_q, gen_q, matte_q;
   logic [31:0] rd_mux; // Read data selection
   logic hit_w; // Address maps to a register
   logic setup_w; // APB setup cycle
   logic wr_w; // Write commits this edge
   logic [7:0] cmd_w; // Command pulses
   logic [8:0] lev_s1_q, lev_s2_q; // Lever synchroniser
   logic [10:0] hcnt_q, vcnt_q; // Raster position
   trans_state_t state_q, state_d;
   logic [8:0] pos_q, pos_d; // Main transition position
   logic cut_pend_q; // Cut waits for a field edge
   logic lever_top_q; // Lever sits at far end
   logic black_q; // Output held at black
   logic [NKEY-1:0] on_q; // Keys on air in current stack
   logic [8:0] lev_w, lev_eff;
   logic [9:0] pos_sum;
   logic start_auto, start_lever, done_w, to_black;
   logic [NKEY-1:0] kdone_w;
   logic [8:0] kpos_q [NKEY];
   logic [NKEY-1:0] kbusy_q;
   logic [NKEY-1:0] next_on;
   logic [7:0] next_prio;
   logic [PW-1:0] bg_cur, bg_next, cur_w, next_w, cur_out, next_out;
   logic [PW-1:0] comp_w [2][NKEY];
   logic [8:0] pat0, pat1, f_w;
   logic wipe_hit;
   logic [NKEY-1:0] mask_w;

   // Threshold of a pattern at the current raster point
   function automatic logic [8:0] pattern(input logic [1:0] shape, input logic [10:0] x,
                                          input logic [10:0] y);
      logic [10:0] dx;
      logic [10:0] dy;
      dx = (x > 11'h3C0) ? x - 11'h3C0 : 11'h3C0 - x;
      dy = (y > 11'h21C) ? y - 11'h21C : 11'h21C - y;
      unique case (shape)
         2'd0: return x[10:2];
         2'd1: return y[10:2];
         2'd2: return (dx > dy) ? dx[10:2] : dy[10:2];
         2'd3: return 9'((x + y) >> 3);
      endcase
   endfunction : pattern

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   assign setup_w = psel && !penable;
   assign wr_w = psel && penable && pready && pwrite && !pslverr;
   assign cmd_w = (wr_w && paddr == A_CMD) ? pwdata[7:0] : 8'h00;
   assign hit_w = (paddr[1:0] == 2'b00) && (paddr <= A_STAT);
   assign rd_mux = (paddr == A_CTRL) ? ctrl_q :
                   (paddr == A_RATE) ? rate_q :
                   (paddr == A_KRATE) ? krate_q :
                   (paddr == A_BUS) ? bus_q :
                   (paddr == A_PRIO) ? prio_q :
                   (paddr == A_KCFG) ? kcfg_q :
                   (paddr == A_CLIP) ? clip_q :
                   (paddr == A_GEN) ? gen_q :
                   (paddr == A_MATTE) ? matte_q :
                   (paddr == A_STAT) ? {13'h0000, kbusy_q, on_q, black_q,
                                        state_q != ST_IDLE, pos_q} : 32'h00000000;

   // Zero-wait slave: answer in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup_w;
         pslverr <= setup_w && !hit_w;
         prdata <= (setup_w && hit_w && !pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // Software registers; bus and priority also move at completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= R_CTRL;
         rate_q <= R_RATE;
         krate_q <= R_KRATE;
         bus_q <= R_BUS;
         prio_q <= R_PRIO;
         kcfg_q <= 32'h00000000;
         clip_q <= R_CLIP;
         gen_q <= R_GEN;
         matte_q <= R_MATTE;
      end else begin
         if (wr_w && paddr == A_CTRL) ctrl_q <= pwdata;
         if (wr_w && paddr == A_RATE) rate_q <= pwdata;
         if (wr_w && paddr == A_KRATE) krate_q <= pwdata;
         if (wr_w && paddr == A_KCFG) kcfg_q <= pwdata;
         if (wr_w && paddr == A_CLIP) clip_q <= pwdata;
         if (wr_w && paddr == A_GEN) gen_q <= pwdata;
         if (wr_w && paddr == A_MATTE) matte_q <= pwdata;
         // Flip-flop the buses on a completed background transition
         if (done_w && !to_black && ctrl_q[C_BG]) begin
            bus_q <= {28'h0000000, bus_q[1:0], bus_q[3:2]}; // [RULE7] [RULE22]
         end else if (wr_w && paddr == A_BUS) begin
            bus_q <= pwdata;
         end
         // New priority order becomes current
         if (done_w && !to_black && ctrl_q[C_PRIO]) begin
            prio_q <= {16'h0000, prio_q[15:8], prio_q[15:8]}; // [RULE12]
         end else if (wr_w && paddr == A_PRIO) begin
            prio_q <= pwdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lever pin synchroniser and raster counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lev_s1_q <= 9'h000;
         lev_s2_q <= 9'h000;
      end else begin
         lev_s1_q <= lever_pos;
         lev_s2_q <= lev_s1_q;
      end
   end

   // Pixel and line position within the field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt_q <= 11'h000;
         vcnt_q <= 11'h000;
      end else begin
         if (field_start) vcnt_q <= 11'h000;
         else if (line_start) vcnt_q <= vcnt_q + 11'h001;
         if (line_start || field_start) hcnt_q <= 11'h000;
         else if (pix_valid) hcnt_q <= hcnt_q + 11'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main transition sequencer
   assign lev_w = (lev_s2_q > F_FULL) ? F_FULL : lev_s2_q;
   assign lev_eff = lever_top_q ? F_FULL - lev_w : lev_w; // [RULE5]
   assign pos_sum = 10'(pos_q) + 10'(rate_q[8:0]);
   assign start_auto = cmd_w[M_AUTO] && ctrl_q[1:0] != TT_CUT; // [RULE5]
   assign start_lever = ctrl_q[C_LEVER] && field_start && lev_eff != '0; // [RULE5]
   // Completion only at a field edge
   assign done_w = field_start && (cut_pend_q ||
                   (state_q == ST_AUTO && pos_sum >= 10'(F_FULL)) ||
                   (state_q == ST_LEVER && lev_eff == F_FULL)); // [RULE19] [RULE22]
   // First preset black command goes to black, second comes out
   assign to_black = ctrl_q[C_PBLK] && !black_q; // [RULE4]

   // Next state and position, stepped once per field
   always_comb begin
      state_d = state_q;
      pos_d = pos_q;
      if (done_w) begin
         state_d = ST_IDLE;
         pos_d = 9'h000;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_auto) state_d = ST_AUTO;
               else if (start_lever) begin
                  state_d = ST_LEVER;
                  pos_d = lev_eff;
               end
            end
            ST_AUTO: begin
               if (field_start) pos_d = pos_sum[8:0]; // [RULE21]
            end
            ST_LEVER: begin
               if (field_start) pos_d = lev_eff; // [RULE21]
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         pos_q <= 9'h000;
         cut_pend_q <= 1'b0;
         lever_top_q <= 1'b0;
         black_q <= 1'b0;
         on_q <= '0;
      end else begin
         state_q <= state_d;
         pos_q <= pos_d;
         // A cut has no duration; a command on the field edge waits for the next one
         if (cmd_w[M_CUT] || (cmd_w[M_AUTO] && ctrl_q[1:0] == TT_CUT)) cut_pend_q <= 1'b1;
         else if (field_start) cut_pend_q <= 1'b0; // [RULE19]
         if (done_w && state_q == ST_LEVER) lever_top_q <= !lever_top_q;
         if (done_w) black_q <= to_black; // [RULE4]
         on_q <= on_q ^ kdone_w ^ ((done_w && !to_black) ? ctrl_q[C_KEY+:NKEY] : '0); // [RULE9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Key mix sequencers, one rate and trigger per keyer
   for (genvar k = 0; k < NKEY; k++) begin : g_kmix
      logic [9:0] ksum;
      assign ksum = 10'(kpos_q[k]) + 10'(krate_q[8*k+:8]);
      assign kdone_w[k] = kbusy_q[k] && field_start && ksum >= 10'(F_FULL); // [RULE6]
      // Start on own trigger, step per field
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            kbusy_q[k] <= 1'b0;
            kpos_q[k] <= 9'h000;
         end else if (kdone_w[k]) begin
            kbusy_q[k] <= 1'b0;
            kpos_q[k] <= 9'h000;
         end else if (cmd_w[M_KMIX+k]) begin
            kbusy_q[k] <= 1'b1; // [RULE6]
         end else if (kbusy_q[k] && field_start) begin
            kpos_q[k] <= ksum[8:0]; // [RULE21]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stacks: background at the bottom, keys layered by priority
   assign next_on = on_q ^ ctrl_q[C_KEY+:NKEY]; // [RULE9]
   assign next_prio = ctrl_q[C_PRIO] ? prio_q[15:8] : prio_q[7:0]; // [RULE9] [RULE12]
   assign bg_cur = src_video[bus_q[1:0]]; // [RULE7]
   assign bg_next = ctrl_q[C_BG] ? src_video[bus_q[3:2]] : bg_cur; // [RULE9]

   for (genvar k = 0; k < NKEY; k++) begin : g_mask
      // Per keyer simple and box generators for masking
      assign mask_w[k] = kcfg_q[8*k+K_MBOX] ? (pattern(2'd2, hcnt_q, vcnt_q) < 9'(gen_q[15:8]))
                         : (pattern(2'd0, hcnt_q, vcnt_q) < 9'(gen_q[15:8])); // [RULE3]
   end

   for (genvar s = 0; s < 2; s++) begin : g_stack
      for (genvar i = 0; i < NKEY; i++) begin : g_slot
         logic [1:0] idx;
         logic [8:0] op;
         logic [PW-1:0] below;
         // Slot 0 sits just above background, last slot on top
         assign idx = (s == 0) ? prio_q[2*i+:2] : next_prio[2*i+:2]; // [RULE11]
         assign below = (i == 0) ? ((s == 0) ? bg_cur : bg_next) : comp_w[s][i-1]; // [RULE11]
         // Next stack keys are fully keyed; current ones follow key mix
         assign op = (s == 1) ? (next_on[idx] ? F_FULL : 9'h000) :
                     kbusy_q[idx] ? (on_q[idx] ? F_FULL - kpos_q[idx] : kpos_q[idx]) :
                     (on_q[idx] ? F_FULL : 9'h000); // [RULE6] [RULE10]
         key_layer u_key (
            .bg(below),
            .cut(key_cut[idx]),
            .fill(key_fill[idx]),
            .matte(matte_q[PW-1:0]),
            .cfg(kcfg_q[8*idx+:8]),
            .clip(clip_q[PW-1:0]),
            .gain(clip_q[16+:PW]),
            .opacity(op),
            .mask_in(mask_w[idx]),
            .comp(comp_w[s][i])
         );
      end
   end

   assign cur_w = comp_w[0][NKEY-1];
   assign next_w = comp_w[1][NKEY-1];
   // Black replaces the whole picture, selected elements or not
   assign cur_out = black_q ? BLACK : cur_w; // [RULE4]
   assign next_out = to_black ? BLACK : next_w; // [RULE4]

   ////////////////////////////////////////////////////////////////////////////
   // Wipe systems on the two complex generators
   assign pat0 = pattern(gen_q[1:0], hcnt_q, vcnt_q); // [RULE3]
   assign pat1 = pattern(gen_q[3:2], hcnt_q, vcnt_q); // [RULE3]
   // Each wipe system picks either complex generator
   assign wipe_hit = (ctrl_q[C_WBG] && ((ctrl_q[C_W0G] ? pat1 : pat0) < pos_q)) || // [RULE2]
                     (ctrl_q[C_WKEY] && ((ctrl_q[C_W1G] ? pat1 : pat0) < pos_q)); // [RULE1]
   assign f_w = (ctrl_q[1:0] == TT_WIPE) ? (wipe_hit ? F_FULL : 9'h000) : pos_q; // [RULE1] [RULE20]

   // Program blends whole current into whole next; preview looks ahead
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pgm_video <= BLACK;
         pvw_video <= BLACK;
         out_valid <= 1'b0;
      end else begin
         pgm_video <= blend(cur_out, next_out, f_w); // [RULE10] [RULE20]
         pvw_video <= next_out; // [RULE8]
         out_valid <= pix_valid;
      end
   end
endmodule : me_compositor

// file: verif/comp_properties.sv
`timescale 1ns/1ps
module comp_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pix_valid,
   input wire logic out_valid,
   input wire logic field_start
);
   // One clock domain
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Setup cycle with an unmapped or misaligned address
   wire bad_setup = psel && !penable && (paddr[1:0] != 2'h0 || paddr > 8'h28);
   wire good_setup = psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h28;
   a_ready_setup:
      assert property (psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_cause:
      assert property (pready |-> $past(psel && !penable) && psel && penable)
      else $error("ready without setup");
   a_ready_pulse:
      assert property (pready |=> !pready) else $error("ready longer than a cycle");
   a_err_unmapped:
      assert property (bad_setup |=> pslverr) else $error("unmapped access not refused");
   a_err_mapped:
      assert property (good_setup |=> !pslverr) else $error("mapped access refused");
   a_err_nodata:
      assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
   a_rdata_idle:
      assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
   a_valid_rise:
      assert property (pix_valid |=> out_valid) else $error("out valid missed");
   a_valid_fall:
      assert property (!pix_valid |=> !out_valid) else $error("out valid spurious");
   // Main scenarios reached
   c_err: cover property (pslverr);
   c_read: cover property (pready && !pslverr);
   c_field: cover property (field_start && out_valid);
endmodule : comp_checker
bind me_compositor comp_checker chk_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pix_valid(pix_valid), .out_valid(out_valid), .field_start(field_start));

// file: verif/panel_model.sv
`timescale 1ns/1ps
module panel_model (
   input wire logic pclk,
   input wire logic presetn,
   output logic pix_valid,
   output logic line_start,
   output logic field_start,
   output logic [3:0][comp_pkg::PW-1:0] src_video,
   output logic [3:0][comp_pkg::PW-1:0] key_cut,
   output logic [3:0][comp_pkg::PW-1:0] key_fill,
   output logic [8:0] lever_pos
);
   import comp_pkg::*;
   logic [5:0] cnt_q; // Pixel count in a short field
   // Raster timing: 16 pixel lines, 64 pixel fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 6'h00;
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
   assign field_start = (cnt_q == 6'h3F);
   assign line_start = (cnt_q[3:0] == 4'hF);
   assign pix_valid = (cnt_q[3:0] != 4'h0); // Blanking pixel each line
   assign lever_pos = 9'h000; // Lever at rest
   // Flat sources; dark cut keeps keys out of the picture
   for (genvar i = 0; i < 4; i++) begin : g_src
      assign src_video[i] = 10'h100 + 10'(i * 128);
      assign key_cut[i] = 10'h000;
      assign key_fill[i] = 10'h3FF;
   end
endmodule : panel_model

// file: verif/tb.sv
`timescale 1ns/1ps
`define chk(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
   import comp_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e_q;
   logic pix_valid, line_start, field_start, out_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [3:0][PW-1:0] src_video, key_cut, key_fill;
   logic [8:0] lever_pos;
   logic [PW-1:0] pgm_video, pvw_video;
   int num_errors = 0;
   int num_checks = 0;
   localparam logic [7:0] RA [8] = '{A_CTRL, A_RATE, A_KRATE, A_BUS,
                                     A_PRIO, A_CLIP, A_GEN, A_MATTE};
   localparam logic [31:0] RV [8] = '{R_CTRL, R_RATE, R_KRATE, R_BUS,
                                      R_PRIO, R_CLIP, R_GEN, R_MATTE};
   me_compositor #(.NSRC(4)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pix_valid(pix_valid), .line_start(line_start),
      .field_start(field_start), .src_video(src_video), .key_cut(key_cut),
      .key_fill(key_fill), .lever_pos(lever_pos), .pgm_video(pgm_video),
      .pvw_video(pvw_video), .out_valid(out_valid));
   panel_model src_i (.pclk(pclk), .presetn(presetn), .pix_valid(pix_valid),
      .line_start(line_start), .field_start(field_start), .src_video(src_video),
      .key_cut(key_cut), .key_fill(key_fill), .lever_pos(lever_pos));
   ////////////////////////////////////////////////////////////////////////////
   // Clock at 20 MHz
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // One APB transfer, answer taken at the ready edge
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) num_errors++;
      rd_q = prdata;
      e_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(a, 1'b0, 32'h0);
      `chk("prdata", x, rd_q)
   endtask : rd
   // Settle a few pixels past the next field boundary
   task wf;
      @(negedge pclk iff field_start === 1'b1);
      repeat (3) @(negedge pclk);
   endtask : wf
   task close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      close_out;
   end
   // Test sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd(RA[i], RV[i]);
      rd(8'h2C, 32'h0);
      `chk("pslverr", 1'b1, e_q)
      rd(8'h02, 32'h0);
      `chk("pslverr", 1'b1, e_q)
      apb(A_STAT, 1'b1, 32'hFFFFFFFF);
      rd(A_STAT, 32'h0);
      // Background cut from source 0 to source 1
      wf;
      apb(A_CTRL, 1'b1, 32'h004);
      apb(A_CMD, 1'b1, 32'h2);
      `chk("pvw", 10'h180, pvw_video)
      `chk("pgm", 10'h100, pgm_video)
      wf;
      `chk("pgm", 10'h180, pgm_video)
      `chk("pvw", 10'h100, pvw_video)
      rd(A_BUS, 32'h1);
      // Auto mix back to source 0 in two fields
      apb(A_CTRL, 1'b1, 32'h005);
      apb(A_RATE, 1'b1, 32'h080);
      wf;
      apb(A_CMD, 1'b1, 32'h1);
      wf;
      rd(A_STAT, 32'h280);
      `chk("pgm", 10'((384 * 128 + 256 * 128) / 256), pgm_video)
      wf;
      `chk("pgm", 10'h100, pgm_video)
      rd(A_BUS, 32'h4);
      rd(A_STAT, 32'h0);
      // Preset black: two cuts, into and out of black
      apb(A_CTRL, 1'b1, 32'h100);
      apb(A_CMD, 1'b1, 32'h2);
      wf;
      `chk("pgm", BLACK, pgm_video)
      rd(A_STAT, 32'h400);
      apb(A_CMD, 1'b1, 32'h2);
      wf;
      `chk("pgm", 10'h100, pgm_video)
      rd(A_STAT, 32'h0);
      // Key 0 mix on its own trigger; dark cut keeps fill out
      apb(A_CMD, 1'b1, 32'h10);
      rd(A_STAT, 32'h8000);
      `chk("pgm", 10'h100, pgm_video)
      close_out;
   end
endmodule : tb
